// ===== rtl/ess_defs.svh
// Timing and limit constants of the energy state sequencer
//
// Function
// - Enable high starts device, low powers down
// - Enable low pulses under 3.4 us ignored; only resetThr is floored, a pdThr below it still powers down
// - Longer pulse resets; longer still powers down
// - Host drops enable before supply falls
// - Pad supply, select pins valid before enable
// - Tied enable: selects stable within 100 us
// - Ready for operation within 1 ms
// - Select pins sampled at boot only
// - Full power: clocks on, host link usable
// - Power-down ignores events, pins high impedance
// - Leaving power-down resets whole internal state
// - Standby: enable stays high, state kept
// - Standby exits on host, poll, probe events
// - Standby wake schedule runs without host
// - Low-power clock during ramp-up and standby
// - PLL makes system clock from reference
// - Reference accepted from 13.15 to 52 MHz
// - Delta-sigma modulator sets fractional divide
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH

// Clock rate of clk_sys in MHz
`define ESS_CLK_MHZ 10
// Shortest enable low pulse that is acted on, in ns
`define ESS_IGNORE_NS 3400
// Least time rounds up to whole cycles
`define ESS_IGNORE_CYC ((`ESS_IGNORE_NS * `ESS_CLK_MHZ + 999) / 1000)
// Boot to ready time, in us; longest time rounds down
`define ESS_READY_US 1000
`define ESS_READY_CYC (`ESS_READY_US * `ESS_CLK_MHZ)
// Host settling time of select pins before enable, in us
`define ESS_SETUP_US 100
`define ESS_SETUP_CYC (`ESS_SETUP_US * `ESS_CLK_MHZ)
// Accepted reference clock range, in kHz
`define ESS_REF_MIN_KHZ 16'h335E
`define ESS_REF_MAX_KHZ 16'hCB20
// Divide word layout: integer part above, fraction below
`define ESS_DIV_FRAC_W 16
`define ESS_DIV_INT_LSB 16
`define ESS_DIV_INT_MSB 23
// Pin synchroniser bit positions
`define ESS_PIN_EN 0
`define ESS_PIN_SEL_LSB 1
`define ESS_PIN_SEL_MSB 2
`define ESS_PIN_ACT 3

`endif

// ===== rtl/ess_pkg.sv
// Types shared by both ends of the energy state sequencer
package ess_pkg;

    // Energy state of the device
    typedef enum logic [1:0] {
        ESS_PD = 2'b00,
        ESS_BOOT = 2'b01,
        ESS_FULL = 2'b10,
        ESS_STANDBY_STATE = 2'b11
    } ess_state_e;

    // Sequencing state of the host controller
    typedef enum logic [1:0] {
        ESS_H_OFF = 2'b00,
        ESS_H_SETUP = 2'b01,
        ESS_H_ON = 2'b10,
        ESS_H_PULSE = 2'b11
    } ess_host_e;

endpackage

// ===== rtl/ess_link_if.sv
// Pin-level link between host controller and device
`timescale 1ns/100ps
`default_nettype none
interface ess_link_if;
    // Chip enable, driven only by the host
    logic chipEnable;
    // Interface select pins, host drive and enable
    logic [1:0] ifSelOut;
    logic [1:0] ifSelOe;
    // Host interface activity strobe level
    logic hostActivity;
    // General-purpose pins, device drive and enable
    logic [7:0] gpioDevOut;
    logic [7:0] gpioDevOe;

    // Device end
    modport device (
        input chipEnable, ifSelOut, ifSelOe, hostActivity,
        output gpioDevOut, gpioDevOe
    );
    // Host end
    modport host (
        output chipEnable, ifSelOut, ifSelOe, hostActivity,
        input gpioDevOut, gpioDevOe
    );
endinterface
`default_nettype wire

// ===== rtl/ess_device_end.sv
// Device end: enable decoding, energy states, clock selection
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ess_device_end #(
    parameter int unsigned READY_CYCLES = `ESS_READY_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Pins toward the host
    ess_link_if.device link,
    // Enable pulse thresholds in clk_sys cycles
    input wire logic [15:0] resetThr,
    input wire logic [15:0] pdThr,
    // Standby request and wake sources
    input wire logic standbyReq,
    input wire logic [2:0] wakeEn,
    input wire logic pollDue,
    input wire logic cardProbeHit,
    input wire logic fieldProbeHit,
    // Reference and PLL setup
    input wire logic refExternal,
    input wire logic [15:0] refKhz,
    input wire logic [23:0] divWord,
    // General-purpose pin requests from the core
    input wire logic [7:0] gpioOutReq,
    input wire logic [7:0] gpioOeReq,
    // Status toward the core
    output var ess_pkg::ess_state_e energyState,
    output var logic coreResetPulse,
    output var logic hostLinkReady,
    output var logic [1:0] hostIfSel,
    // Clock generation controls
    output var logic sysClkFromPll,
    output var logic pllEnable,
    output var logic pllRefExternal,
    output var logic refOk,
    output var logic [7:0] pllDivN
);

    // Three-stage pin synchroniser, one vector for all pins
    logic [3:0] pinA_r;
    logic [3:0] pinB_r;
    logic [3:0] pinC_r;
    logic [3:0] pinClean_r;
    // Pin vector as sampled from the link
    wire [3:0] pinRaw = {link.hostActivity,
                         link.ifSelOut & link.ifSelOe,
                         link.chipEnable};

    // Low-time counter of the enable pin
    logic [15:0] lowCnt_r;
    // Boot delay counter
    logic [31:0] bootCnt_r;
    // Delta-sigma fraction accumulator
    logic [15:0] fracAcc_r;
    // Present and next energy state
    ess_pkg::ess_state_e state_r;
    ess_pkg::ess_state_e stateNxt;

    // Decoded enable level and pulse outcome
    wire enLow = ~pinClean_r[`ESS_PIN_EN];
    wire pulseEnd = ~enLow && (lowCnt_r != 16'h0000);
    // Floor of the reset threshold: shorter pulses never cause softReset
    wire [15:0] ignoreCyc = 16'(`ESS_IGNORE_CYC);
    wire [15:0] resetCyc = (resetThr < ignoreCyc) ? ignoreCyc : resetThr;
    // Low long enough: power down while still low
    wire goPd = enLow && (lowCnt_r >= pdThr);
    // Released between the two thresholds: reset only
    wire softReset = pulseEnd && (lowCnt_r >= resetCyc)
                     && (lowCnt_r < pdThr);
    // Boot delay done
    wire bootDone = (bootCnt_r >= READY_CYCLES - 1);
    // Any enabled wake source
    wire wake = (wakeEn[0] & pinClean_r[`ESS_PIN_ACT])
              | (wakeEn[1] & pollDue)
              | (wakeEn[2] & (cardProbeHit | fieldProbeHit));
    // Reference within the accepted band
    wire refInBand = (refKhz >= `ESS_REF_MIN_KHZ)
                     && (refKhz <= `ESS_REF_MAX_KHZ);
    // Entry into boot, from power-down or from a reset pulse
    wire enterBoot = (stateNxt == ess_pkg::ESS_BOOT)
                     && ((state_r != ess_pkg::ESS_BOOT) || softReset);
    // PLL runs only in full power with a valid reference
    wire pllOnNxt = (stateNxt == ess_pkg::ESS_FULL) && refInBand;
    // Delta-sigma sum with carry into the integer divide
    wire [16:0] fracSum = {1'b0, fracAcc_r}
                        + {1'b0, divWord[`ESS_DIV_FRAC_W-1:0]};
    wire [7:0] divInt = divWord[`ESS_DIV_INT_MSB:`ESS_DIV_INT_LSB];
    wire [7:0] divNxt = pllOnNxt ? divInt + {7'h00, fracSum[16]}
                                 : divInt;

    // Next energy state
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            // Leaves only once the enable is high again
            ess_pkg::ESS_PD: begin
                if (!enLow) begin
                    stateNxt = ess_pkg::ESS_BOOT;
                end
            end
            // Ramp-up on the low-power clock
            ess_pkg::ESS_BOOT: begin
                if (goPd) begin
                    stateNxt = ess_pkg::ESS_PD;
                end else if (!softReset && bootDone && !enLow) begin
                    stateNxt = ess_pkg::ESS_FULL;
                end
            end
            // Normal operation
            ess_pkg::ESS_FULL: begin
                if (goPd) begin
                    stateNxt = ess_pkg::ESS_PD;
                end else if (softReset) begin
                    stateNxt = ess_pkg::ESS_BOOT;
                end else if (standbyReq) begin
                    stateNxt = ess_pkg::ESS_STANDBY_STATE;
                end
            end
            // Standby keeps state apart from the PLL and hostLinkReady; wakes on its own sources
            ess_pkg::ESS_STANDBY_STATE: begin
                if (goPd) begin
                    stateNxt = ess_pkg::ESS_PD;
                end else if (softReset) begin
                    stateNxt = ess_pkg::ESS_BOOT;
                end else if (wake) begin
                    stateNxt = ess_pkg::ESS_FULL;
                end
            end
            default: begin
                stateNxt = ess_pkg::ESS_PD;
            end
        endcase
    end

    // Synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinA_r <= 4'h0;
            pinB_r <= 4'h0;
            pinC_r <= 4'h0;
            pinClean_r <= 4'h0;
        end else begin
            pinA_r <= pinRaw;
            pinB_r <= pinA_r;
            pinC_r <= pinB_r;
            pinClean_r <= (pinB_r & pinC_r) | (pinClean_r & (pinB_r | pinC_r));
        end
    end

    // Enable low-time measurement, saturating
    always_ff @(posedge clk_sys) begin
        if (reset || !enLow) begin
            lowCnt_r <= 16'h0000;
        end else if (lowCnt_r != 16'hFFFF) begin
            lowCnt_r <= lowCnt_r + 16'h0001;
        end
    end

    // Boot delay counter restarts on each entry into boot
    always_ff @(posedge clk_sys) begin
        if (reset || enterBoot) begin
            bootCnt_r <= 32'h0000_0000;
        end else if (state_r == ess_pkg::ESS_BOOT && !bootDone) begin
            bootCnt_r <= bootCnt_r + 32'h0000_0001;
        end
    end

    // State register; standby stops the PLL and drops hostLinkReady, leaves the rest untouched
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ess_pkg::ESS_PD;
            energyState <= ess_pkg::ESS_PD;
        end else begin
            state_r <= stateNxt;
            energyState <= stateNxt;
        end
    end

    // Core reset pulse on leaving power-down or on a reset pulse
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            coreResetPulse <= 1'b0;
        end else begin
            coreResetPulse <= enterBoot;
        end
    end

    // Select pins captured once, at the end of boot
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hostIfSel <= 2'b00;
        end else if (state_r == ess_pkg::ESS_BOOT
                     && stateNxt == ess_pkg::ESS_FULL) begin
            hostIfSel <= pinClean_r[`ESS_PIN_SEL_MSB:`ESS_PIN_SEL_LSB];
        end
    end

    // Clock source: PLL only in full power, else low-power clock
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sysClkFromPll <= 1'b0;
            pllEnable <= 1'b0;
            pllRefExternal <= 1'b0;
            refOk <= 1'b0;
            hostLinkReady <= 1'b0;
        end else begin
            sysClkFromPll <= pllOnNxt;
            pllEnable <= pllOnNxt;
            pllRefExternal <= refExternal;
            refOk <= refInBand;
            hostLinkReady <= (stateNxt == ess_pkg::ESS_FULL);
        end
    end

    // First-order delta-sigma dithers the integer divide word
    always_ff @(posedge clk_sys) begin
        if (reset || !pllOnNxt) begin
            fracAcc_r <= 16'h0000;
            pllDivN <= 8'h00;
        end else begin
            fracAcc_r <= fracSum[15:0];
            pllDivN <= divNxt;
        end
    end

    // Pins released to high impedance in power-down
    always_ff @(posedge clk_sys) begin
        if (reset || stateNxt == ess_pkg::ESS_PD) begin
            link.gpioDevOut <= 8'h00;
            link.gpioDevOe <= 8'h00;
        end else begin
            link.gpioDevOut <= gpioOutReq;
            link.gpioDevOe <= gpioOeReq;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/ess_host_end.sv
// Host end: drives enable and select pins in the right order
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ess_host_end (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Pins toward the device
    ess_link_if.host link,
    // Requests from host software
    input wire logic wantOn,
    input wire logic supplyLow,
    input wire logic [1:0] ifSelCfg,
    input wire logic pulseReq,
    input wire logic [15:0] pulseCycles,
    input wire logic hostTouch,
    // Status
    output var ess_pkg::ess_host_e hostState,
    output var logic hostBusy
);

    // Sequencer state and its cycle counter
    ess_pkg::ess_host_e state_r;
    ess_pkg::ess_host_e stateNxt;
    logic [15:0] cnt_r;
    // Select-pin settle time before enable rises
    wire [15:0] setupCyc = 16'(`ESS_SETUP_CYC);
    wire cntDone = (cnt_r == 16'h0000);

    // Next host state
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            // Enable low until power is wanted and good
            ess_pkg::ESS_H_OFF: begin
                if (wantOn && !supplyLow) begin
                    stateNxt = ess_pkg::ESS_H_SETUP;
                end
            end
            // Selects driven and settling, enable still low
            ess_pkg::ESS_H_SETUP: begin
                if (supplyLow || !wantOn) begin
                    stateNxt = ess_pkg::ESS_H_OFF;
                end else if (cntDone) begin
                    stateNxt = ess_pkg::ESS_H_ON;
                end
            end
            // Enable held high, through standby as well
            ess_pkg::ESS_H_ON: begin
                if (supplyLow || !wantOn) begin
                    stateNxt = ess_pkg::ESS_H_OFF;
                end else if (pulseReq && pulseCycles != 16'h0000) begin
                    stateNxt = ess_pkg::ESS_H_PULSE;
                end
            end
            // Timed low pulse on enable
            ess_pkg::ESS_H_PULSE: begin
                if (supplyLow || !wantOn) begin
                    stateNxt = ess_pkg::ESS_H_OFF;
                end else if (cntDone) begin
                    stateNxt = ess_pkg::ESS_H_ON;
                end
            end
            default: begin
                stateNxt = ess_pkg::ESS_H_OFF;
            end
        endcase
    end

    // State and counter; counter loads on entry to a timed state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ess_pkg::ESS_H_OFF;
            cnt_r <= 16'h0000;
        end else begin
            state_r <= stateNxt;
            if (stateNxt == ess_pkg::ESS_H_SETUP && state_r != stateNxt) begin
                cnt_r <= setupCyc - 16'h0001;
            end else if (stateNxt == ess_pkg::ESS_H_PULSE
                         && state_r != stateNxt) begin
                cnt_r <= pulseCycles - 16'h0001;
            end else if (!cntDone) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            link.chipEnable <= 1'b0;
            link.ifSelOut <= 2'b00;
            link.ifSelOe <= 2'b00;
            link.hostActivity <= 1'b0;
            hostState <= ess_pkg::ESS_H_OFF;
            hostBusy <= 1'b0;
        end else begin
            // Enable drops first whenever supply is failing
            link.chipEnable <= (stateNxt == ess_pkg::ESS_H_ON);
            // Selects stay driven before and while enable is high
            link.ifSelOut <= ifSelCfg;
            link.ifSelOe <= (stateNxt == ess_pkg::ESS_H_OFF) ? 2'b00 : 2'b11;
            link.hostActivity <= hostTouch && (stateNxt == ess_pkg::ESS_H_ON);
            hostState <= stateNxt;
            hostBusy <= (stateNxt == ess_pkg::ESS_H_SETUP)
                        || (stateNxt == ess_pkg::ESS_H_PULSE);
        end
    end

endmodule
`default_nettype wire

// ===== bench/ess_link_monitor.sv
// Pin-level checker for the energy state sequencer link
`timescale 1ns/100ps
`default_nettype none
module ess_link_monitor #(
    parameter int PD_CYC = 200
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Host-driven pins
    input wire logic chipEnable,
    input wire logic [1:0] ifSelOut,
    input wire logic [1:0] ifSelOe,
    input wire logic hostActivity,
    // Device-driven pins
    input wire logic [7:0] gpioDevOut,
    input wire logic [7:0] gpioDevOe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic [15:0] lowCnt_r; // Cycles of enable low, saturating
    logic [15:0] selCnt_r; // Cycles of driven selects with enable low
    logic onSeen_r; // Enable has run with selects driven

    // Counters restart at every level change so each pulse is timed alone
    always_ff @(posedge clk_sys) begin
        if (reset || chipEnable) begin
            lowCnt_r <= 16'h0000;
        end else if (lowCnt_r != 16'hFFFF) begin
            lowCnt_r <= lowCnt_r + 16'h0001;
        end
    end

    // Setup time only counts while selects are really driven
    always_ff @(posedge clk_sys) begin
        if (reset || chipEnable || ifSelOe != 2'b11) begin
            selCnt_r <= 16'h0000;
        end else if (selCnt_r != 16'hFFFF) begin
            selCnt_r <= selCnt_r + 16'h0001;
        end
    end

    // Separates a first rise from the rise that ends a short pulse
    always_ff @(posedge clk_sys) begin
        if (reset || ifSelOe != 2'b11) begin
            onSeen_r <= 1'b0;
        end else if (chipEnable) begin
            onSeen_r <= 1'b1;
        end
    end

    AST_RESET_QUIET: assert property (disable iff (1'b0)
        reset |=> !chipEnable && ifSelOe == 2'b00 && gpioDevOe == 8'h00)
        else $error("link not quiet after reset");
    AST_PD_HIZ: assert property (
        lowCnt_r >= PD_CYC + 8 |-> gpioDevOe == 8'h00 && gpioDevOut == 8'h00)
        else $error("device drives pins in power-down");
    AST_SEL_FIRST: assert property (
        $rose(chipEnable) |-> ifSelOe == 2'b11)
        else $error("enable rose without driven selects");
    AST_ACT_IN_RUN: assert property (hostActivity |-> chipEnable)
        else $error("host activity with enable low");
    AST_SEL_SETUP: assert property (
        $rose(chipEnable) && !onSeen_r |-> selCnt_r >= 16'h03E8)
        else $error("selects driven too briefly before enable");
    AST_EN_WITH_SEL: assert property (chipEnable |-> ifSelOe == 2'b11)
        else $error("selects released while enabled");
    AST_SEL_STEADY: assert property (
        chipEnable && $past(chipEnable) |-> $stable(ifSelOut))
        else $error("selects changed while enabled");
    AST_BOOT_QUIET: assert property (
        $rose(chipEnable) && gpioDevOe == 8'h00 |=> (gpioDevOe == 8'h00) [*2])
        else $error("pins driven before enable was seen");
    AST_PD_EXIT: assert property (
        $rose(chipEnable) && $past(lowCnt_r) >= PD_CYC
        |-> (gpioDevOe == 8'h00) [*3])
        else $error("pins driven on leaving power-down");
endmodule
`default_nettype wire

// ===== bench/energy_state_sequencer_tb_top.sv
// Self-checking bench joining host end and device end
`timescale 1ns/100ps
`default_nettype none
module energy_state_sequencer_tb_top;
    localparam int RDY = 20; // Shortened boot time
    localparam int PDW = 200; // Power-down width in cycles
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    // Device user side
    logic [15:0] resetThr = 16'h0014;
    logic [15:0] pdThr = 16'h00C8;
    logic standbyReq = 1'b0;
    logic [2:0] wakeEn = 3'h0;
    logic pollDue = 1'b0;
    logic cardProbeHit = 1'b0;
    logic fieldProbeHit = 1'b0;
    logic refExternal = 1'b0;
    logic [15:0] refKhz = 16'h69F0;
    logic [23:0] divWord = 24'h100000;
    logic [7:0] gpioOutReq = 8'h3C;
    logic [7:0] gpioOeReq = 8'hA5;
    ess_pkg::ess_state_e energyState;
    logic coreResetPulse, hostLinkReady, sysClkFromPll, pllEnable;
    logic pllRefExternal, refOk;
    logic [1:0] hostIfSel;
    logic [7:0] pllDivN;
    // Host user side
    logic wantOn = 1'b0;
    logic supplyLow = 1'b0;
    logic [1:0] ifSelCfg = 2'b10;
    logic pulseReq = 1'b0;
    logic [15:0] pulseCycles = 16'h0000;
    logic hostTouch = 1'b0;
    ess_pkg::ess_host_e hostState;
    logic hostBusy;
    // Bookkeeping
    int errors = 0;
    int num_checks = 0;
    int rstSeen = 0;
    int pdSeen = 0;
    int r0, p0, i, sum;
    logic [15:0] ws [4] = '{16'h0021, 16'h0022, 16'h00C7, 16'h0104};
    logic [15:0] rk [4] = '{16'h335D, 16'h335E, 16'hCB20, 16'hCB21};

    ess_link_if link();
    ess_device_end #(.READY_CYCLES(RDY)) u_ess_device_end (.clk_sys, .reset,
        .link(link), .resetThr, .pdThr, .standbyReq, .wakeEn, .pollDue,
        .cardProbeHit, .fieldProbeHit, .refExternal, .refKhz, .divWord,
        .gpioOutReq, .gpioOeReq, .energyState, .coreResetPulse,
        .hostLinkReady, .hostIfSel, .sysClkFromPll, .pllEnable,
        .pllRefExternal, .refOk, .pllDivN);
    ess_host_end u_ess_host_end (.clk_sys, .reset, .link(link), .wantOn,
        .supplyLow, .ifSelCfg, .pulseReq, .pulseCycles, .hostTouch,
        .hostState, .hostBusy);
    ess_link_monitor #(.PD_CYC(PDW)) u_ess_link_monitor (.clk_sys, .reset,
        .chipEnable(link.chipEnable), .ifSelOut(link.ifSelOut),
        .ifSelOe(link.ifSelOe), .hostActivity(link.hostActivity),
        .gpioDevOut(link.gpioDevOut), .gpioDevOe(link.gpioDevOe));

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    // Soft resets and power-down cycles are tallied, as they can be brief
    always @(posedge clk_sys) begin
        if (coreResetPulse === 1'b1) begin
            rstSeen++;
        end
        if (energyState === ess_pkg::ESS_PD) begin
            pdSeen++;
        end
    end

    // Verdict and end of run
    task automatic close_out();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Inputs change just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Bounded wait for an energy state; a hang ends the run
    task automatic wait_es(input ess_pkg::ess_state_e s, input int lim);
        int n;
        n = 0;
        while (energyState !== s && n < lim) begin
            tick(1);
            n++;
        end
        if (energyState !== s) begin
            errors++;
            $display("CHECK FAILED energyState expected %0h seen %0h", s,
                     energyState);
            close_out();
        end
    endtask

    // Full start-up from power-down with a given select setting
    task automatic power_up(input logic [1:0] sel);
        int n;
        ifSelCfg = sel;
        wantOn = 1'b1;
        tick(2);
        chk("hostBusy", 1, hostBusy);
        wait_es(ess_pkg::ESS_BOOT, 1300);
        n = 0;
        while (energyState === ess_pkg::ESS_BOOT && n < 100) begin
            tick(1);
            n++;
        end
        chk("bootCycles", 1, n >= RDY && n <= RDY + 1);
        chk("energyState", ess_pkg::ESS_FULL, energyState);
        chk("hostLinkReady", 1, hostLinkReady);
        chk("hostIfSel", sel, hostIfSel);
        chk("hostBusy", 0, hostBusy);
    endtask

    // One low pulse on enable, requested from the host end
    task automatic pulse(input logic [15:0] w);
        pulseCycles = w;
        pulseReq = 1'b1;
        tick(1);
        pulseReq = 1'b0;
        tick(w + 20);
    endtask

    initial begin
        tick(2);
        reset = 1'b0;
        chk("energyState", ess_pkg::ESS_PD, energyState);
        chk("gpioDevOe", 0, link.gpioDevOe);
        power_up(2'b10);
        chk("gpioDevOe", 8'hA5, link.gpioDevOe);
        chk("gpioDevOut", 8'h3C, link.gpioDevOut);
        // Ignore, reset at both limits, then power-down
        for (i = 0; i < 4; i++) begin
            r0 = rstSeen;
            p0 = pdSeen;
            pulse(ws[i]);
            wait_es(ess_pkg::ESS_FULL, 400);
            chk("softResets", i > 0, rstSeen - r0);
            chk("pdEntered", i == 3, pdSeen > p0);
        end
        // Standby keeps state and stops the PLL
        standbyReq = 1'b1;
        tick(1);
        standbyReq = 1'b0;
        wait_es(ess_pkg::ESS_STANDBY_STATE, 10);
        chk("pllEnable", 0, pllEnable);
        chk("gpioDevOe", 8'hA5, link.gpioDevOe);
        pollDue = 1'b1;
        tick(8);
        chk("energyState", ess_pkg::ESS_STANDBY_STATE, energyState);
        pollDue = 1'b0;
        // Each wake source on its own, sources used by the schedule
        for (i = 0; i < 4; i++) begin
            standbyReq = 1'b1;
            tick(1);
            standbyReq = 1'b0;
            wait_es(ess_pkg::ESS_STANDBY_STATE, 10);
            wakeEn = 3'h1 << ((i > 2) ? 2 : i);
            hostTouch = (i == 0);
            pollDue = (i == 1);
            cardProbeHit = (i == 2);
            fieldProbeHit = (i == 3);
            wait_es(ess_pkg::ESS_FULL, 20);
            {hostTouch, pollDue, cardProbeHit, fieldProbeHit} = 4'h0;
            tick(6);
        end
        // Reference range edges
        for (i = 0; i < 4; i++) begin
            refKhz = rk[i];
            tick(4);
            chk("refOk", i == 1 || i == 2, refOk);
            chk("pllEnable", i == 1 || i == 2, pllEnable);
        end
        refKhz = 16'h69F0;
        refExternal = 1'b1;
        divWord = 24'h108000;
        tick(4);
        chk("sysClkFromPll", 1, sysClkFromPll);
        chk("pllRefExternal", 1, pllRefExternal);
        // Half fraction: every second cycle carries
        sum = 0;
        for (i = 0; i < 8; i++) begin
            sum += pllDivN;
            tick(1);
        end
        chk("divSum", 132, sum);
        // Supply failing: enable drops at once, then power-down
        supplyLow = 1'b1;
        tick(1);
        chk("chipEnable", 0, link.chipEnable);
        wait_es(ess_pkg::ESS_PD, PDW + 50);
        chk("hostState", ess_pkg::ESS_H_OFF, hostState);
        chk("gpioDevOe", 0, link.gpioDevOe);
        supplyLow = 1'b0;
        wantOn = 1'b0;
        tick(2);
        power_up(2'b01);
        close_out();
    end
endmodule
`default_nettype wire
